// ==== zqpd_pkg.sv ====
// shared constants, command set and timing counts for the calibration / power-down link
package zqpd_pkg;
    typedef enum logic [2:0] {
        ZQPD_NOP, ZQPD_ACT, ZQPD_PRE, ZQPD_RD, ZQPD_RDA, ZQPD_WR, ZQPD_MRW, ZQPD_REF
    } zqpd_cmd_t;

    localparam logic [7:0] MA_ZQ      = 8'h0a;
    localparam logic [7:0] ZQ_OP_INIT = 8'h10;
    localparam logic [7:0] ZQ_OP_LONG = 8'h20;
    localparam logic [7:0] ZQ_OP_SHRT = 8'h30;
    localparam logic [7:0] ZQ_OP_RST  = 8'h40;

    localparam int CK_PS       = 50000;
    localparam int T_ZQINIT_PS = 1000000;
    localparam int T_ZQCL_PS   = 360000;
    localparam int T_ZQCS_PS   = 90000;
    localparam int T_XP_PS     = 7500;
    localparam int T_CKE_PS    = 15000;
    localparam int T_RTP_PS    = 7500;
    localparam int T_RAS_PS    = 42000;
    localparam int T_WR_PS     = 15000;
    localparam int T_DQSCK_PS  = 5500;
    localparam int STABLE_CLKS = 2;
    localparam int MRW_CYC     = 5;

    // least times round up, never below one cycle
    function automatic int zqpd_cyc(input int ps);
        zqpd_cyc = (ps + CK_PS - 1) / CK_PS;
        if (zqpd_cyc < 1) zqpd_cyc = 1;
    endfunction

    localparam int ZQINIT_CYC = zqpd_cyc(T_ZQINIT_PS);
    localparam int ZQCL_CYC   = zqpd_cyc(T_ZQCL_PS);
    localparam int ZQCS_CYC   = zqpd_cyc(T_ZQCS_PS);
    localparam int XP_CYC     = zqpd_cyc(T_XP_PS);
    localparam int CKE_CYC    = zqpd_cyc(T_CKE_PS) > STABLE_CLKS ? zqpd_cyc(T_CKE_PS)
                                                                 : STABLE_CLKS;
    localparam int RTP_CYC    = zqpd_cyc(T_RTP_PS);
    localparam int RAS_CYC    = zqpd_cyc(T_RAS_PS);
    localparam int WR_CYC     = zqpd_cyc(T_WR_PS);
    localparam int DQSCK_CYC  = zqpd_cyc(T_DQSCK_PS);
endpackage

// ==== zqpd_if.sv ====
// link between memory controller end and device end
`timescale 1ns/10ps
`default_nettype none
interface zqpd_if;
    import zqpd_pkg::*;
    logic       cke;
    logic       cs_n;
    zqpd_cmd_t  cmd;
    logic [7:0] ma;
    logic [7:0] op;
    logic       dq_oe;
    modport ctrl (output cke, cs_n, cmd, ma, op, input dq_oe);
    modport dev  (input cke, cs_n, cmd, ma, op, output dq_oe);
endinterface
`default_nettype wire

// ==== zqpd_device.sv ====
// device end: calibration engine, power-down states, auto precharge timing
`timescale 1ns/10ps
`default_nettype none
module zqpd_device #(
    parameter int RL = 3,
    parameter int BL = 4
) (
    input  wire logic ref_clk_in,      // link clock
    input  wire logic rst_in,          // async reset, high
    zqpd_if.dev       link,            // command side
    input  wire logic zq_tied_in,      // zq pin strapped to supply
    output logic      pd_idle_out,     // idle power-down
    output logic      pd_active_out,   // active power-down
    output logic      zq_busy_out,     // calibration running
    output logic      zq_pin_en_out,   // zq pin circuitry on
    output logic      imp_cal_out,     // calibrated (1) or default (0)
    output logic      auto_pre_out,    // internal precharge pulse
    output logic [7:0] banks_open_out  // open row per bank
);
    import zqpd_pkg::*;

    if (RL + BL > 200 || BL < 4) $error("zqpd_device: RL/BL out of range");

    typedef enum logic [1:0] {ZQPD_D_IDLE, ZQPD_D_ZQ, ZQPD_D_PD} zqpd_dst_t;
    typedef struct packed {
        zqpd_dst_t  st;
        logic       cke_q;
        logic [7:0] open;
        logic [7:0] zcnt;
        logic       ap_pend;
        logic [2:0] ap_bank;
        logic [7:0] ap_cnt;
        logic [7:0] ras_cnt;
        logic [7:0] rd_cnt;
        logic       dq_oe;
        logic       cal;
        logic       pd_act;
        logic       ap_pulse;
        logic [2:0] tie_sync;
        logic       tied;
    } zqpd_dev_s_t;

    zqpd_dev_s_t s_r, s_nxt;
    logic [7:0] ap_wait;

    always_comb begin
        ap_wait = 8'(BL / 2);
        if (8'(RTP_CYC) > ap_wait) ap_wait = 8'(RTP_CYC);
        if (s_r.ras_cnt > ap_wait) ap_wait = s_r.ras_cnt;
        s_nxt = s_r;
        s_nxt.cke_q = link.cke;
        s_nxt.ap_pulse = 1'b0;
        s_nxt.tie_sync = {s_r.tie_sync[1:0], zq_tied_in};
        if (s_r.tie_sync[1] == s_r.tie_sync[2]) s_nxt.tied = s_r.tie_sync[2];
        if (s_r.ras_cnt != 8'h00) s_nxt.ras_cnt = s_r.ras_cnt - 8'h01;
        if (s_r.rd_cnt != 8'h00) s_nxt.rd_cnt = s_r.rd_cnt - 8'h01;
        s_nxt.dq_oe = (s_nxt.rd_cnt != 8'h00) && (s_nxt.rd_cnt <= 8'(BL / 2));
        // auto precharge still completes inside power-down
        if (s_r.ap_pend) begin
            if (s_r.ap_cnt <= 8'h01) begin
                s_nxt.ap_pend = 1'b0;
                s_nxt.ap_pulse = 1'b1;
                s_nxt.open[s_r.ap_bank] = 1'b0;
            end else begin
                s_nxt.ap_cnt = s_r.ap_cnt - 8'h01;
            end
        end
        case (s_r.st)
            ZQPD_D_IDLE: begin
                if (s_r.cke_q && !link.cke && link.cs_n) begin
                    s_nxt.st = ZQPD_D_PD;
                    s_nxt.pd_act = |s_r.open;
                end else if (link.cke && !link.cs_n) begin
                    case (link.cmd)
                        ZQPD_ACT: begin
                            s_nxt.open[link.ma[2:0]] = 1'b1;
                            s_nxt.ras_cnt = 8'(RAS_CYC);
                        end
                        ZQPD_PRE: s_nxt.open[link.ma[2:0]] = 1'b0;
                        ZQPD_RD:  s_nxt.rd_cnt = 8'(RL + BL / 2);
                        ZQPD_RDA: begin
                            s_nxt.rd_cnt = 8'(RL + BL / 2);
                            s_nxt.ap_pend = 1'b1;
                            s_nxt.ap_bank = link.ma[2:0];
                            s_nxt.ap_cnt = ap_wait;
                        end
                        ZQPD_MRW: begin
                            // strapped pin: calibration codes are dropped
                            if (link.ma == MA_ZQ && !s_r.tied) begin
                                case (link.op)
                                    ZQ_OP_INIT: s_nxt.zcnt = 8'(ZQINIT_CYC);
                                    ZQ_OP_LONG: s_nxt.zcnt = 8'(ZQCL_CYC);
                                    ZQ_OP_SHRT: s_nxt.zcnt = 8'(ZQCS_CYC);
                                    default:    s_nxt.zcnt = 8'h00;
                                endcase
                                if (link.op == ZQ_OP_RST) s_nxt.cal = 1'b0;
                                if (s_nxt.zcnt != 8'h00) s_nxt.st = ZQPD_D_ZQ;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            ZQPD_D_ZQ: begin
                s_nxt.zcnt = s_r.zcnt - 8'h01;
                if (s_r.zcnt <= 8'h01) begin
                    s_nxt.st = ZQPD_D_IDLE;
                    s_nxt.cal = 1'b1;
                end
            end
            ZQPD_D_PD: begin
                // all inputs but cke ignored; no refresh happens here
                if (link.cke) s_nxt.st = ZQPD_D_IDLE;
            end
            default: s_nxt.st = ZQPD_D_IDLE;
        endcase
        if (s_r.tied) s_nxt.cal = 1'b0;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.dq_oe    = s_r.dq_oe;
    assign pd_idle_out   = (s_r.st == ZQPD_D_PD) && !s_r.pd_act;
    assign pd_active_out = (s_r.st == ZQPD_D_PD) && s_r.pd_act;
    assign zq_busy_out   = (s_r.st == ZQPD_D_ZQ);
    assign zq_pin_en_out = (s_r.st == ZQPD_D_ZQ);
    assign imp_cal_out   = s_r.cal;
    assign auto_pre_out  = s_r.ap_pulse;
    assign banks_open_out = s_r.open;
endmodule
`default_nettype wire

// ==== zqpd_ctrl.sv ====
// controller end: command issue, calibration and power-down timers
//
// Behaviour
// - calibration starts by mode write to 0Ah
// - run init calibration before trusting impedance
// - calibrate only idle, all banks precharged
// - data bus quiet during calibration
// - only NOPs while calibration runs
// - clock enable high through calibration
// - calibration reset needs no quiet time
// - shared resistor: no overlapping calibrations
// - strapped calibration pin ignores calibration commands
// - repeat short calibration within drift interval
// - calibration pin circuitry off when done
// - power-down entry with chip select high
// - no power-down during reads, writes, mode writes
// - classify idle versus active power-down
// - in power-down only clock enable matters
// - clock enable held minimum time both ways
// - exit power-down in time for refresh
// - exit with chip select high
// - wait exit latency before next command
// - two stable clocks before power-down exit
// - read burst ends before clock enable low
// - read auto precharge internal timing
// - write recovery before clock enable low
`timescale 1ns/10ps
`default_nettype none
module zqpd_ctrl #(
    parameter int RL         = 3,
    parameter int WL         = 1,
    parameter int BL         = 4,
    parameter int ZQCS_INT   = 8000000,
    parameter int PD_MAX_CYC = 70000
) (
    input  wire logic               ref_clk_in,       // controller clock
    input  wire logic               rst_in,           // async reset, high
    zqpd_if.ctrl                    link,             // device side
    input  wire logic               req_valid_in,     // command request
    input  wire zqpd_pkg::zqpd_cmd_t req_cmd_in,      // command kind
    input  wire logic [7:0]         req_ma_in,        // bank or register address
    input  wire logic [7:0]         req_op_in,        // mode write data
    output logic                    req_ready_out,    // request taken this edge
    input  wire logic               pd_req_in,        // power-down request; exit forced after PD_MAX_CYC cycles
    input  wire logic               zq_share_busy_in, // other device calibrating
    output logic                    zq_active_out,    // this device calibrating
    output logic                    pd_out,           // clock enable held low
    output logic                    imp_ok_out,       // init calibration done
    output logic                    zqcs_due_out,     // short calibration due
    output logic [7:0]              banks_open_out    // open row per bank
);
    import zqpd_pkg::*;

    localparam int RD_PD = RL + DQSCK_CYC + BL / 2 + 1;
    localparam int WR_PD = WL + 1 + BL / 2 + WR_CYC;

    if (RD_PD > 255 || WR_PD > 255 || BL < 4) $error("zqpd_ctrl: latency out of range");
    if (ZQCS_INT < 1 || PD_MAX_CYC < CKE_CYC) $error("zqpd_ctrl: interval too short");
    // the waits live in 8-bit counters
    if (ZQINIT_CYC > 255 || ZQCL_CYC > 255) $error("zqpd_ctrl: wait count too wide");

    typedef enum logic [1:0] {ZQPD_C_RUN, ZQPD_C_PD} zqpd_cst_t;
    typedef struct packed {
        zqpd_cst_t   st;
        logic        cke;
        logic        cs_n;
        zqpd_cmd_t   cmd;
        logic [7:0]  ma;
        logic [7:0]  op;
        logic [7:0]  open;
        logic [7:0]  wait_cnt;
        logic [7:0]  ckel_cnt;
        logic [7:0]  hold_cnt;
        logic        zq_run;
        logic        zq_init_run;
        logic        init_done;
        logic [31:0] pd_cnt;
        logic [31:0] zqcs_cnt;
        logic        due;
    } zqpd_ctl_s_t;

    zqpd_ctl_s_t s_r, s_nxt;
    logic is_zq;
    logic zq_quiet;
    logic legal;
    logic ready;

    always_comb begin
        is_zq    = (req_cmd_in == ZQPD_MRW) && (req_ma_in == MA_ZQ);
        zq_quiet = is_zq && (req_op_in != ZQ_OP_RST);
        legal    = 1'b1;
        if (is_zq && s_r.open != 8'h00) legal = 1'b0;
        if (req_cmd_in == ZQPD_MRW && s_r.open != 8'h00) legal = 1'b0;
        // burst data and write recovery must be over before any mode write
        if (req_cmd_in == ZQPD_MRW && s_r.ckel_cnt != 8'h00) legal = 1'b0;
        if (zq_quiet && zq_share_busy_in) legal = 1'b0;
        if (req_cmd_in == ZQPD_NOP) legal = 1'b0;
        // pending power-down request wins over new commands
        ready = (s_r.st == ZQPD_C_RUN) && (s_r.wait_cnt == 8'h00)
                && !pd_req_in && legal;
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.cs_n = 1'b1;
        s_nxt.cmd = ZQPD_NOP;
        if (s_r.wait_cnt != 8'h00) s_nxt.wait_cnt = s_r.wait_cnt - 8'h01;
        if (s_r.ckel_cnt != 8'h00) s_nxt.ckel_cnt = s_r.ckel_cnt - 8'h01;
        if (s_r.hold_cnt != 8'h00) s_nxt.hold_cnt = s_r.hold_cnt - 8'h01;
        if (s_r.wait_cnt <= 8'h01 && s_r.zq_run) begin
            s_nxt.zq_run = 1'b0;
            if (s_r.zq_init_run) s_nxt.init_done = 1'b1;
            s_nxt.zq_init_run = 1'b0;
        end
        // interval counts from init calibration done, then from the last long or short calibration
        if (s_r.init_done && !s_r.due) s_nxt.zqcs_cnt = s_r.zqcs_cnt + 32'h1;
        case (s_r.st)
            ZQPD_C_RUN: begin
                // wait_cnt also covers calibration, so clock enable stays high
                if (s_r.wait_cnt == 8'h00 && pd_req_in && s_r.ckel_cnt == 8'h00
                    && s_r.hold_cnt == 8'h00) begin
                    s_nxt.cke = 1'b0;
                    s_nxt.st = ZQPD_C_PD;
                    s_nxt.hold_cnt = 8'(CKE_CYC);
                    s_nxt.pd_cnt = 32'h0;
                end else if (req_valid_in && ready) begin
                    s_nxt.cs_n = 1'b0;
                    s_nxt.cmd = req_cmd_in;
                    s_nxt.ma = req_ma_in;
                    s_nxt.op = req_op_in;
                    case (req_cmd_in)
                        ZQPD_ACT: s_nxt.open[req_ma_in[2:0]] = 1'b1;
                        ZQPD_PRE: s_nxt.open[req_ma_in[2:0]] = 1'b0;
                        ZQPD_RD:  s_nxt.ckel_cnt = 8'(RD_PD);
                        ZQPD_RDA: begin
                            s_nxt.ckel_cnt = 8'(RD_PD);
                            s_nxt.open[req_ma_in[2:0]] = 1'b0;
                        end
                        ZQPD_WR:  s_nxt.ckel_cnt = 8'(WR_PD);
                        ZQPD_MRW: begin
                            s_nxt.wait_cnt = 8'(MRW_CYC);
                            if (is_zq) begin
                                case (req_op_in)
                                    ZQ_OP_INIT: s_nxt.wait_cnt = 8'(ZQINIT_CYC);
                                    ZQ_OP_LONG: s_nxt.wait_cnt = 8'(ZQCL_CYC);
                                    ZQ_OP_SHRT: s_nxt.wait_cnt = 8'(ZQCS_CYC);
                                    default:    s_nxt.wait_cnt = 8'(MRW_CYC);
                                endcase
                                // only NOPs and no data while wait_cnt runs
                                s_nxt.zq_run = zq_quiet;
                                s_nxt.zq_init_run = (req_op_in == ZQ_OP_INIT);
                                if (req_op_in == ZQ_OP_LONG || req_op_in == ZQ_OP_SHRT) begin
                                    s_nxt.due = 1'b0;
                                    s_nxt.zqcs_cnt = 32'h0;
                                end
                            end
                        end
                        default: ;
                    endcase
                end
            end
            ZQPD_C_PD: begin
                s_nxt.pd_cnt = s_r.pd_cnt + 32'h1;
                // other pins are don't-care to the device; only cke is held
                s_nxt.cke = 1'b0;
                // hold_cnt >= two cycles also gives the stable clocks before exit
                if (s_r.hold_cnt == 8'h00 && (!pd_req_in
                    || s_r.pd_cnt >= 32'(PD_MAX_CYC))) begin
                    s_nxt.cke = 1'b1;
                    s_nxt.cs_n = 1'b1;
                    s_nxt.st = ZQPD_C_RUN;
                    s_nxt.hold_cnt = 8'(CKE_CYC);
                    s_nxt.wait_cnt = 8'(XP_CYC);
                end
            end
            default: s_nxt.st = ZQPD_C_RUN;
        endcase

        // interval end beats a calibration issued in the same cycle
        if (s_r.init_done && !s_r.due && s_r.zqcs_cnt >= 32'(ZQCS_INT - 1)) begin
            s_nxt.due = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_r <= '{st: ZQPD_C_RUN, cke: 1'b1, cs_n: 1'b1, cmd: ZQPD_NOP, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.cke       = s_r.cke;
    assign link.cs_n      = s_r.cs_n;
    assign link.cmd       = s_r.cmd;
    assign link.ma        = s_r.ma;
    assign link.op        = s_r.op;
    assign req_ready_out  = ready;
    assign zq_active_out  = s_r.zq_run;
    assign pd_out         = (s_r.st == ZQPD_C_PD);
    assign imp_ok_out     = s_r.init_done;
    assign zqcs_due_out   = s_r.due;
    assign banks_open_out = s_r.open;
endmodule
`default_nettype wire

// ==== zqpd_checker.sv ====
// link-level checks between controller end and device end
`timescale 1ns/10ps
`default_nettype none
module zqpd_checker
    import zqpd_pkg::*;
(
    input wire logic      ref_clk_in, // link clock
    input wire logic      rst_in,     // async reset, high
    input wire logic      cke,        // clock enable
    input wire logic      cs_n,       // chip select, low active
    input wire zqpd_pkg::zqpd_cmd_t cmd, // command
    input wire logic [7:0] ma,        // address
    input wire logic [7:0] op,        // mode write data
    input wire logic      dq_oe       // device drives data
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    logic       iss;
    logic       zq_cal;
    logic [7:0] quiet_r;
    logic [7:0] quiet_nxt;
    assign iss    = cke && !cs_n;
    assign zq_cal = iss && cmd == ZQPD_MRW && ma == MA_ZQ
                    && (op == ZQ_OP_INIT || op == ZQ_OP_LONG || op == ZQ_OP_SHRT);

    // one short of the count: the exact end cycle is left loose
    always_comb begin
        quiet_nxt = (quiet_r != 8'h00) ? quiet_r - 8'h01 : 8'h00;
        if (zq_cal) begin
            quiet_nxt = (op == ZQ_OP_INIT) ? 8'(ZQINIT_CYC - 1)
                      : (op == ZQ_OP_LONG) ? 8'(ZQCL_CYC - 1) : 8'(ZQCS_CYC - 1);
        end
    end
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) quiet_r <= 8'h00;
        else        quiet_r <= quiet_nxt;
    end

    AST_PD_ENTRY_NOP: assert property ($fell(cke) |-> cs_n ##1 cs_n)
        else $error("power-down entry without nop");
    AST_PD_INPUTS_IDLE: assert property (!cke |-> cs_n)
        else $error("command driven in power-down");
    AST_CKE_LOW_MIN: assert property ($fell(cke) |=> !cke)
        else $error("clock enable low too short");
    AST_CKE_HIGH_MIN: assert property ($rose(cke) |=> cke)
        else $error("clock enable high too short");
    AST_EXIT_CS_XP: assert property ($rose(cke) |-> cs_n ##1 (cs_n && cke))
        else $error("power-down exit timing broken");
    AST_ZQ_QUIET: assert property (quiet_r != 8'h00 |-> cs_n && cke && !dq_oe)
        else $error("activity during calibration");
    AST_RD_CKE: assert property (iss && (cmd == ZQPD_RD || cmd == ZQPD_RDA) |=> cke[*6])
        else $error("clock enable low during read burst");
    AST_WR_CKE: assert property (iss && cmd == ZQPD_WR |=> cke[*4])
        else $error("clock enable low before write recovery");
    AST_MRW_CKE: assert property (iss && cmd == ZQPD_MRW |=> cke[*4])
        else $error("clock enable low during mode write");

    cover property (zq_cal);
    cover property ($fell(cke));
    cover property (iss && cmd == ZQPD_RD);
    cover property (iss && cmd == ZQPD_WR);
endmodule
`default_nettype wire

// ==== zq_cal_powerdown_ctrl_tb.sv ====
// self-checking bench: controller and device joined over the link
`timescale 1ns/10ps
`default_nettype none
module zq_cal_powerdown_ctrl_tb;
    import zqpd_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid = 1'b0;
    zqpd_cmd_t req_cmd = ZQPD_NOP;
    logic [7:0] req_ma = 8'h00;
    logic [7:0] req_op = 8'h00;
    logic pd_req = 1'b0;
    logic share_busy = 1'b0;
    logic zq_tied = 1'b0;
    logic req_ready, zq_active, pd, imp_ok, zqcs_due;
    logic pd_idle, pd_active, zq_busy, zq_pin_en, imp_cal, auto_pre;
    logic [7:0] c_banks, d_banks;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    localparam int BL_HALF = 2;

    zqpd_if link ();
    zqpd_ctrl #(.ZQCS_INT(50), .PD_MAX_CYC(40)) i_zqpd_ctrl (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .link(link), .req_valid_in(req_valid), .req_cmd_in(req_cmd),
        .req_ma_in(req_ma), .req_op_in(req_op), .req_ready_out(req_ready), .pd_req_in(pd_req),
        .zq_share_busy_in(share_busy), .zq_active_out(zq_active), .pd_out(pd),
        .imp_ok_out(imp_ok), .zqcs_due_out(zqcs_due), .banks_open_out(c_banks));
    zqpd_device i_zqpd_device (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link),
        .zq_tied_in(zq_tied), .pd_idle_out(pd_idle), .pd_active_out(pd_active),
        .zq_busy_out(zq_busy), .zq_pin_en_out(zq_pin_en), .imp_cal_out(imp_cal),
        .auto_pre_out(auto_pre), .banks_open_out(d_banks));
    zqpd_checker i_zqpd_checker (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .cke(link.cke),
        .cs_n(link.cs_n), .cmd(link.cmd), .ma(link.ma), .op(link.op), .dq_oe(link.dq_oe));

    always #25 ref_clk_in = ~ref_clk_in;

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard, well above the whole sequence
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk_in);
        #1;
    endtask
    // request held until the edge that takes it; returns edges waited
    task automatic issue(input zqpd_cmd_t c, input logic [7:0] a, input logic [7:0] o);
        req_cmd = c;
        req_ma = a;
        req_op = o;
        req_valid = 1'b1;
        n = 0;
        // ready is combinational: looked at mid-cycle, where it has settled
        do begin
            @(negedge ref_clk_in);
            n++;
        end while (req_ready !== 1'b1);
        tick(1);
        req_valid = 1'b0;
        tick(1);
    endtask
    task automatic zq_done();
        for (int i = 0; i < 80 && (zq_busy !== 1'b0 || zq_active !== 1'b0); i++) tick(1);
        tick(2);
    endtask
    task automatic pd_leave();
        pd_req = 1'b0;
        for (int i = 0; i < 20 && pd !== 1'b0; i++) tick(1);
        tick(2);
    endtask
    // request that must stay refused for several cycles
    task automatic refused(input string name, input zqpd_cmd_t c, input logic [7:0] o);
        logic hit;
        hit = 1'b0;
        req_cmd = c;
        req_ma = MA_ZQ;
        req_op = o;
        req_valid = 1'b1;
        // every cycle counts: a taken request would hide behind its own wait
        repeat (4) begin
            @(negedge ref_clk_in);
            hit = hit | req_ready;
        end
        tick(1);
        chk(name, hit, 1'b0);
        req_valid = 1'b0;
        tick(1);
    endtask
    task automatic t_zq_init();
        chk("imp_ok_before", imp_ok, 1'b0);
        issue(ZQPD_MRW, MA_ZQ, ZQ_OP_INIT);
        tick(2);
        chk("zq_busy", zq_busy, 1'b1);
        chk("zq_pin_on", zq_pin_en, 1'b1);
        zq_done();
        chk("zq_pin_off", zq_pin_en, 1'b0);
        chk("imp_ok", imp_ok, 1'b1);
        chk("imp_cal", imp_cal, 1'b1);
    endtask
    task automatic t_zq_ops();
        for (int i = 0; i < 60 && zqcs_due !== 1'b1; i++) tick(1);
        chk("zqcs_due", zqcs_due, 1'b1);
        for (int j = 0; j < 2; j++) begin
            issue(ZQPD_MRW, MA_ZQ, j == 0 ? ZQ_OP_LONG : ZQ_OP_SHRT);
            chk("zq_active", zq_active, 1'b1);
            zq_done();
        end
        chk("zqcs_cleared", zqcs_due, 1'b0);
    endtask
    task automatic t_zq_rst();
        issue(ZQPD_MRW, MA_ZQ, ZQ_OP_RST);
        chk("rst_no_active", zq_active, 1'b0);
        issue(ZQPD_ACT, 8'h01, 8'h00);
        chk("rst_resume", 8'(n <= MRW_CYC + 2), 8'h01);
        chk("rst_imp_cal", imp_cal, 1'b0);
        issue(ZQPD_PRE, 8'h01, 8'h00);
    endtask
    task automatic t_share();
        share_busy = 1'b1;
        refused("share_refuse", ZQPD_MRW, ZQ_OP_SHRT);
        issue(ZQPD_MRW, MA_ZQ, ZQ_OP_RST);
        chk("share_rst_taken", zq_active, 1'b0);
        share_busy = 1'b0;
    endtask
    task automatic t_bank_pd();
        issue(ZQPD_ACT, 8'h03, 8'h00);
        tick(2);
        chk("c_banks", c_banks, 8'h08);
        chk("d_banks", d_banks, 8'h08);
        refused("zq_bank_open", ZQPD_MRW, ZQ_OP_SHRT);
        pd_req = 1'b1;
        tick(4);
        chk("pd_cke", link.cke, 1'b0);
        chk("pd_active", pd_active, 1'b1);
        chk("pd_no_issue", req_ready, 1'b0);
        pd_leave();
        issue(ZQPD_PRE, 8'h03, 8'h00);
        pd_req = 1'b1;
        tick(4);
        chk("pd_idle", pd_idle, 1'b1);
        chk("pd_not_active", pd_active, 1'b0);
        n = 0;
        for (int i = 0; i < 100 && pd === 1'b1; i++) begin
            tick(1);
            n++;
        end
        chk("pd_forced_exit", 8'(n <= 42 && n >= CKE_CYC), 8'h01);
        pd_leave();
    endtask
    task automatic t_burst_pd(input zqpd_cmd_t c, input int least);
        issue(ZQPD_ACT, 8'h00, 8'h00);
        issue(c, 8'h00, 8'h00);
        pd_req = 1'b1;
        n = 0;
        for (int i = 0; i < 30 && link.cke !== 1'b0; i++) begin
            tick(1);
            n++;
        end
        chk("burst_to_pd", 8'(n >= least), 8'h01);
        pd_leave();
        issue(ZQPD_PRE, 8'h00, 8'h00);
    endtask
    task automatic t_rda();
        issue(ZQPD_ACT, 8'h02, 8'h00);
        issue(ZQPD_RDA, 8'h02, 8'h00);
        n = 0;
        for (int i = 0; i < 10 && auto_pre !== 1'b1; i++) begin
            tick(1);
            n++;
        end
        chk("auto_pre_delay", 8'(n >= BL_HALF && n <= BL_HALF + 1), 8'h01);
        chk("d_banks_ap", d_banks, 8'h00);
        tick(4);
    endtask
    task automatic t_strap();
        zq_tied = 1'b1;
        tick(5);
        issue(ZQPD_MRW, MA_ZQ, ZQ_OP_INIT);
        tick(3);
        chk("strap_busy", zq_busy, 1'b0);
        chk("strap_imp", imp_cal, 1'b0);
        zq_done();
        zq_tied = 1'b0;
    endtask

    initial begin
        tick(20);
        rst_in = 1'b0;
        tick(1);
        t_zq_init();
        t_zq_ops();
        t_zq_rst();
        t_share();
        t_bank_pd();
        t_burst_pd(ZQPD_RD, 3 + DQSCK_CYC + BL_HALF + 1);
        t_burst_pd(ZQPD_WR, 1 + 1 + BL_HALF + WR_CYC);
        t_rda();
        t_strap();
        close_out();
    end
endmodule
`default_nettype wire
